// File: logic/tpd_pkg.sv
/*
 * Shared constants, types and functions for the tributary pointer demap sink.
 * Assumes a byte-wide group stream of 60 interleaved columns with one
 * frame-start pulse at the first byte of each 500 us multiframe.
 */
`default_nettype none
package tpd_pkg;
    localparam int TPD_BYTE_W = 8;
    localparam int TPD_CNT_W = 10;
    localparam int TPD_NGRP = 20;
    localparam int TPD_NMEM = 3;
    localparam logic [9:0] TPD_NCOL_LAST = 10'h03b;
    localparam logic [9:0] TPD_TU2_QTR = 10'h06c;
    localparam logic [9:0] TPD_TU12_QTR = 10'h024;
    localparam logic [9:0] TPD_TU2_PMAX = 10'h1ab;
    localparam logic [9:0] TPD_TU12_PMAX = 10'h08b;
    localparam logic [3:0] TPD_NDF_NORM = 4'h6;
    localparam logic [3:0] TPD_NDF_EN = 4'h9;
    localparam logic [3:0] TPD_AIS_RUN = 4'h3;
    localparam logic [3:0] TPD_INV_RUN = 4'h8;
    localparam logic [3:0] TPD_EQ_RUN = 4'h3;
    localparam logic [7:0] TPD_ONES = 8'hff;
    localparam int TPD_RESP_TIME_US = 1000;
    localparam int TPD_SYS_CLK_MHZ = 50;
    localparam int TPD_RESP_CYC = TPD_RESP_TIME_US * TPD_SYS_CLK_MHZ;
    localparam int TPD_FIFO_DEPTH = 16;

    typedef enum {TPD_VC2, TPD_VC12, TPD_VC11} tpd_var_e;
    typedef enum {TPD_PI_NORM, TPD_PI_AIS, TPD_PI_LOP} tpd_pi_e;

    typedef struct packed {
        logic                  fs;
        logic [TPD_BYTE_W-1:0] data;
    } tpd_word_s;

    typedef struct packed {
        logic ais;
        logic lop;
        logic tsf;
    } tpd_defect_s;

    // wrapping step shared by the column, tributary and payload counters
    function automatic logic [TPD_CNT_W-1:0] tpd_step(input logic [TPD_CNT_W-1:0] v,
                                                      input logic [TPD_CNT_W-1:0] last);
        return (v == last) ? '0 : v + 10'h001;
    endfunction : tpd_step
endpackage : tpd_pkg
`default_nettype wire

// File: logic/tpd_sync.sv
/*
 * Two-flop level synchroniser, any width.
 * Assumes each bit is a slow level coming from flops in another domain.
 */
`timescale 1ns/1ns
`default_nettype none
module tpd_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             rst_b,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_r;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_r <= '0;
            q      <= '0;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule : tpd_sync
`default_nettype wire

// File: logic/tpd_fifo.sv
/*
 * Dual-clock FIFO with gray-coded pointers, valid/ready on both sides.
 * Assumes DEPTH is a power of two, at least 4; each side has its own reset.
 */
`timescale 1ns/1ns
`default_nettype none
module tpd_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 16
) (
    input  wire logic             wr_clk,
    input  wire logic             wr_rst_b,
    input  wire logic             wr_valid,
    input  wire logic [WIDTH-1:0] wr_data,
    output logic                  wr_ready,
    input  wire logic             rd_clk,
    input  wire logic             rd_rst_b,
    input  wire logic             rd_ready,
    output logic                  rd_valid,
    output logic      [WIDTH-1:0] rd_data
);
    localparam int AW = $clog2(DEPTH);

    function automatic logic [AW:0] to_gray(input logic [AW:0] b);
        return b ^ (b >> 1);
    endfunction : to_gray

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW:0]      wbin_r;
    logic [AW:0]      rbin_r;
    logic [AW:0]      wgray_r;
    logic [AW:0]      rgray_r;
    logic [AW:0]      wgray_s;
    logic [AW:0]      rgray_s;
    logic [AW:0]      wbin_nxt;
    logic [AW:0]      rbin_nxt;
    wire              push = wr_valid && wr_ready;
    wire              pop  = rd_valid && rd_ready;

    // full when the write pointer is one lap ahead of the synced read pointer
    assign wr_ready = wgray_r != {~rgray_s[AW:AW-1], rgray_s[AW-2:0]};
    assign rd_valid = rgray_r != wgray_s;
    assign rd_data  = mem_r[rbin_r[AW-1:0]];
    assign wbin_nxt = wbin_r + (AW+1)'(push);
    assign rbin_nxt = rbin_r + (AW+1)'(pop);

    always_ff @(posedge wr_clk) begin
        if (push) begin
            mem_r[wbin_r[AW-1:0]] <= wr_data;
        end
    end

    always_ff @(posedge wr_clk or negedge wr_rst_b) begin
        if (!wr_rst_b) begin
            wbin_r  <= '0;
            wgray_r <= '0;
        end else begin
            wbin_r  <= wbin_nxt;
            wgray_r <= to_gray(wbin_nxt);
        end
    end

    always_ff @(posedge rd_clk or negedge rd_rst_b) begin
        if (!rd_rst_b) begin
            rbin_r  <= '0;
            rgray_r <= '0;
        end else begin
            rbin_r  <= rbin_nxt;
            rgray_r <= to_gray(rbin_nxt);
        end
    end

    tpd_sync #(.WIDTH(AW+1)) u_w2r (
        .clk   (rd_clk),
        .rst_b (rd_rst_b),
        .d     (wgray_r),
        .q     (wgray_s)
    );

    tpd_sync #(.WIDTH(AW+1)) u_r2w (
        .clk   (wr_clk),
        .rst_b (wr_rst_b),
        .d     (rgray_r),
        .q     (rgray_s)
    );
endmodule : tpd_fifo
`default_nettype wire

// File: logic/tpd_sink.sv
/*
 * Pointer demap sink: picks one tributary from the group stream on the
 * group clock, interprets its V1/V2 pointer and hands the container bytes
 * across a dual-clock FIFO to the sys_clk side, where consequent actions
 * and fault causes are formed.
 * Assumes the group clock runs free and management signals are on sys_clk.
 */
`timescale 1ns/1ns
`default_nettype none
module tpd_sink #(
    parameter tpd_pkg::tpd_var_e VARIANT    = tpd_pkg::TPD_VC12,
    parameter int                GRP_IDX    = 1,
    parameter int                MEM_IDX    = 1,
    parameter int                RESP_CYC   = tpd_pkg::TPD_RESP_CYC,
    parameter int                FIFO_DEPTH = tpd_pkg::TPD_FIFO_DEPTH
) (
    input  wire logic                            sys_clk,
    input  wire logic                            rst_b,
    input  wire logic                            group_input_clock,
    input  wire logic [tpd_pkg::TPD_BYTE_W-1:0]  group_input_data,
    input  wire logic                            group_input_frame_start,
    input  wire logic                            input_trail_fail,
    output logic                                 group_input_ready,
    input  wire logic                            mgmt_activate,
    input  wire logic                            alarm_report_option,
    input  wire logic                            output_ready,
    output logic                                 output_valid,
    output logic      [tpd_pkg::TPD_BYTE_W-1:0]  output_data,
    output logic                                 output_frame_start,
    output logic                                 output_server_fail,
    output logic                                 alarm_fault_cause,
    output logic                                 pointer_loss_fault_cause
);
    import tpd_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // variant geometry

    localparam bit IS_VC2 = (VARIANT == TPD_VC2);
    localparam logic [9:0] QTR   = IS_VC2 ? TPD_TU2_QTR : TPD_TU12_QTR;
    localparam logic [9:0] PMAX  = IS_VC2 ? TPD_TU2_PMAX : TPD_TU12_PMAX;
    localparam logic [9:0] TBLST = 10'((4 * QTR) - 1);
    localparam logic [9:0] SLOT  = 10'(GRP_IDX - 1);
    localparam logic [9:0] COL12 = 10'((GRP_IDX - 1) + TPD_NGRP * (MEM_IDX - 1));
    localparam int         LAG_W = $clog2(RESP_CYC) + 1;

    ////////////////////////////////////////////////////////////////////////////
    // link domain reset: asserted with rst_b, released on the group clock

    logic lrst_meta_r;
    logic lrst_b_r;

    always_ff @(posedge group_input_clock or negedge rst_b) begin
        if (!rst_b) begin
            lrst_meta_r <= 1'b0;
            lrst_b_r    <= 1'b0;
        end else begin
            lrst_meta_r <= 1'b1;
            lrst_b_r    <= lrst_meta_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // tributary selection and multiframe position

    logic [9:0]  col_r;
    logic [9:0]  tb_r;
    logic [9:0]  pay_r;
    logic [7:0]  v1_r;
    wire  [9:0]  col_now = group_input_frame_start ? '0 : col_r;
    wire  [9:0]  tb_now  = group_input_frame_start ? '0 : tb_r;
    wire         hit_vc2 = (col_now % 10'(TPD_NGRP)) == SLOT;
    wire         hit_12  = col_now == COL12;
    wire         sel_hit = IS_VC2 ? hit_vc2 : hit_12;
    wire         is_v1   = tb_now == '0;
    wire         is_v2   = tb_now == QTR;
    wire         is_vx   = is_v1 || is_v2 || (tb_now == 10'(2 * QTR)) || (tb_now == 10'(3 * QTR));
    wire         ptr_evt = sel_hit && is_v2;

    always_ff @(posedge group_input_clock or negedge lrst_b_r) begin
        if (!lrst_b_r) begin
            col_r <= '0;
            tb_r  <= '0;
            pay_r <= '0;
            v1_r  <= '0;
        end else begin
            col_r <= tpd_step(col_now, TPD_NCOL_LAST);
            tb_r  <= sel_hit ? tpd_step(tb_now, TBLST) : tb_now;
            if (sel_hit && is_v1) begin
                v1_r <= group_input_data;
            end
            // payload offset zero is the first byte after V2
            if (ptr_evt) begin
                pay_r <= '0;
            end else if (sel_hit && !is_vx) begin
                pay_r <= tpd_step(pay_r, PMAX);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pointer interpreter

    wire  [3:0] w_ndf   = v1_r[7:4];
    wire  [9:0] w_ptr   = {v1_r[1:0], group_input_data};
    wire        w_ones  = (&v1_r) && (&group_input_data);
    wire        w_valid = w_ptr <= PMAX;
    wire        w_en    = (w_ndf == TPD_NDF_EN) && w_valid;
    wire        w_norm  = (w_ndf == TPD_NDF_NORM) && w_valid;

    tpd_pi_e    pi_st_r;
    tpd_pi_e    pi_nxt;
    logic [9:0] ptr_r;
    logic [9:0] ptr_nxt;
    logic [9:0] cand_r;
    logic [9:0] cand_nxt;
    logic [3:0] ais_cnt_r;
    logic [3:0] ais_nxt;
    logic [3:0] inv_cnt_r;
    logic [3:0] inv_nxt;
    logic [3:0] eq_cnt_r;
    logic [3:0] eq_nxt;
    wire        w_same  = w_ptr == cand_r;

    always_comb begin
        pi_nxt   = pi_st_r;
        ptr_nxt  = ptr_r;
        cand_nxt = cand_r;
        ais_nxt  = ais_cnt_r;
        inv_nxt  = inv_cnt_r;
        eq_nxt   = eq_cnt_r;
        if (ptr_evt) begin
            if (w_ones) begin
                inv_nxt = '0;
                eq_nxt  = '0;
                ais_nxt = (ais_cnt_r == TPD_AIS_RUN - 4'h1) ? ais_cnt_r : ais_cnt_r + 4'h1;
                if (ais_cnt_r == TPD_AIS_RUN - 4'h1) begin
                    pi_nxt = TPD_PI_AIS;
                end
            end else if (w_en) begin
                ais_nxt = '0;
                inv_nxt = '0;
                eq_nxt  = '0;
                ptr_nxt = w_ptr;
                pi_nxt  = TPD_PI_NORM;
            end else if (w_norm) begin
                ais_nxt  = '0;
                inv_nxt  = '0;
                cand_nxt = w_ptr;
                eq_nxt   = (w_same && eq_cnt_r != TPD_EQ_RUN) ? eq_cnt_r + 4'h1 : (w_same ? eq_cnt_r : 4'h1);
                if (w_same && eq_cnt_r >= TPD_EQ_RUN - 4'h1) begin
                    ptr_nxt = w_ptr;
                    pi_nxt  = TPD_PI_NORM;
                end
            end else begin
                ais_nxt = '0;
                eq_nxt  = '0;
                inv_nxt = (inv_cnt_r == TPD_INV_RUN - 4'h1) ? inv_cnt_r : inv_cnt_r + 4'h1;
                if (inv_cnt_r == TPD_INV_RUN - 4'h1) begin
                    pi_nxt = TPD_PI_LOP;
                end
            end
        end
    end

    tpd_defect_s def_l_r;

    // starts in loss of pointer until a pointer is accepted or a run of three all-ones pointers enters the alarm state
    always_ff @(posedge group_input_clock or negedge lrst_b_r) begin
        if (!lrst_b_r) begin
            pi_st_r   <= TPD_PI_LOP;
            ptr_r     <= '0;
            cand_r    <= '0;
            ais_cnt_r <= '0;
            inv_cnt_r <= '0;
            eq_cnt_r  <= '0;
            def_l_r   <= '0;
        end else begin
            pi_st_r   <= pi_nxt;
            ptr_r     <= ptr_nxt;
            cand_r    <= cand_nxt;
            ais_cnt_r <= ais_nxt;
            inv_cnt_r <= inv_nxt;
            eq_cnt_r  <= eq_nxt;
            def_l_r   <= '{ais: pi_st_r == TPD_PI_AIS, lop: pi_st_r == TPD_PI_LOP, tsf: input_trail_fail};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // container bytes into the crossing FIFO

    // bytes keep flowing in alarm states so the output keeps its byte rate
    tpd_word_s wr_word;
    tpd_word_s rd_word;
    wire       wr_valid = sel_hit && !is_vx;
    wire       rd_valid;
    wire       pop;

    assign wr_word.data = group_input_data;
    assign wr_word.fs   = (pi_st_r == TPD_PI_NORM) && (pay_r == ptr_r);

    tpd_fifo #(.WIDTH($bits(tpd_word_s)), .DEPTH(FIFO_DEPTH)) u_fifo (
        .wr_clk   (group_input_clock),
        .wr_rst_b (lrst_b_r),
        .wr_valid (wr_valid),
        .wr_data  (wr_word),
        .wr_ready (group_input_ready),
        .rd_clk   (sys_clk),
        .rd_rst_b (rst_b),
        .rd_ready (output_ready),
        .rd_valid (rd_valid),
        .rd_data  (rd_word)
    );

    ////////////////////////////////////////////////////////////////////////////
    // sys_clk side: consequent actions and fault causes

    tpd_defect_s def_s;

    tpd_sync #(.WIDTH($bits(tpd_defect_s))) u_def_sync (
        .clk   (sys_clk),
        .rst_b (rst_b),
        .d     (def_l_r),
        .q     (def_s)
    );

    logic             report_opt_r;
    logic             after_rst_r;
    logic [LAG_W-1:0] lag_r;
    wire              force_ones_action = def_s.ais || def_s.lop || def_s.tsf;
    wire              blank    = force_ones_action || !mgmt_activate;
    wire              data_nxt_sel = pop && !blank;
    wire  [7:0]       data_nxt = blank ? TPD_ONES : (pop ? rd_word.data : output_data);
    wire              mism     = blank && (output_data != TPD_ONES);
    wire              alarm_nxt = mgmt_activate && def_s.ais && !def_s.tsf && report_opt_r;
    wire              loss_nxt  = mgmt_activate && def_s.lop && !def_s.tsf;

    assign pop = rd_valid && output_ready;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            output_data              <= TPD_ONES;
            output_valid             <= 1'b0;
            output_frame_start       <= 1'b0;
            output_server_fail       <= 1'b1;
            alarm_fault_cause        <= 1'b0;
            pointer_loss_fault_cause <= 1'b0;
            report_opt_r             <= 1'b0;
            after_rst_r              <= 1'b0;
            lag_r                    <= '0;
        end else begin
            output_data              <= data_nxt;
            output_valid             <= pop;
            output_frame_start       <= data_nxt_sel && rd_word.fs;
            output_server_fail       <= force_ones_action;
            alarm_fault_cause        <= alarm_nxt;
            pointer_loss_fault_cause <= loss_nxt;
            report_opt_r             <= alarm_report_option;
            after_rst_r              <= 1'b1;
            lag_r                    <= mism ? lag_r + LAG_W'(1) : '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks

    ais_entry_a: assert property (@(posedge group_input_clock) disable iff (!lrst_b_r)
        (ptr_evt && w_ones && ais_cnt_r == TPD_AIS_RUN - 4'h1) |=> pi_st_r == TPD_PI_AIS)
        else $error("pointer alarm not entered after all-ones run");

    lop_entry_a: assert property (@(posedge group_input_clock) disable iff (!lrst_b_r)
        (ptr_evt && !w_ones && !w_en && !w_norm && inv_cnt_r == TPD_INV_RUN - 4'h1)
        |=> pi_st_r == TPD_PI_LOP)
        else $error("pointer loss not entered after invalid run");

    ptr_accept_a: assert property (@(posedge group_input_clock) disable iff (!lrst_b_r)
        (ptr_evt && !w_ones && w_en) |=> (ptr_r == $past(w_ptr)) && pi_st_r == TPD_PI_NORM)
        else $error("enabled pointer not accepted");

    idle_ones_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        !mgmt_activate |=> output_data == TPD_ONES && !alarm_fault_cause && !pointer_loss_fault_cause)
        else $error("inactive sink not quiet");

    server_fail_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (def_s.ais || def_s.lop || def_s.tsf) |=> output_server_fail && output_data == TPD_ONES)
        else $error("server fail or ones missing on defect");

    ones_lag_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        lag_r < LAG_W'(RESP_CYC))
        else $error("all ones not applied in time");

    resume_data_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (!blank && pop) |=> output_data == $past(rd_word.data) && output_valid)
        else $error("recovered data not delivered");

    alarm_cause_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        alarm_fault_cause |-> $past(def_s.ais && !def_s.tsf && report_opt_r && mgmt_activate))
        else $error("alarm cause without its conditions");

    loss_cause_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (def_s.lop && !def_s.tsf && mgmt_activate) |=> pointer_loss_fault_cause)
        else $error("loss cause missing");

    opt_default_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        !after_rst_r |-> !report_opt_r && !alarm_fault_cause)
        else $error("alarm report option not off after reset");

    col_restart_a: assert property (@(posedge group_input_clock) disable iff (!lrst_b_r)
        group_input_frame_start |=> col_r == 10'h001)
        else $error("column count not restarted at frame start");

    tb_range_a: assert property (@(posedge group_input_clock) disable iff (!lrst_b_r)
        tb_r <= TBLST && pay_r <= PMAX)
        else $error("tributary or payload position out of range");

    ptr_range_a: assert property (@(posedge group_input_clock) disable iff (!lrst_b_r)
        (pi_st_r == TPD_PI_NORM) |-> ptr_r <= PMAX)
        else $error("accepted pointer out of range");

    defect_flag_a: assert property (@(posedge group_input_clock) disable iff (!lrst_b_r)
        (pi_st_r == TPD_PI_LOP) |=> def_l_r.lop && !def_l_r.ais)
        else $error("pointer loss state not flagged");

    frame_mark_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        output_frame_start |-> output_valid && !output_server_fail)
        else $error("frame start outside a delivered byte");

    fail_ones_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        output_server_fail |-> output_data == TPD_ONES)
        else $error("server fail without all ones");

    opt_gate_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        !report_opt_r |=> !alarm_fault_cause)
        else $error("alarm cause with option off");

    tsf_quiet_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        def_s.tsf |=> !alarm_fault_cause && !pointer_loss_fault_cause)
        else $error("fault cause during trail fail");

    loss_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        !def_s.lop |=> !pointer_loss_fault_cause)
        else $error("loss cause without loss defect");
endmodule : tpd_sink
`default_nettype wire

// File: sim/tpd_stream_src.sv
/*
 * Upstream group stream source: 60 byte-interleaved columns, 144 bytes per
 * column and multiframe, V1/V2 only in the chosen column.
 * Assumes the link clock runs free; the sink cannot stall it.
 */
`timescale 1ns/1ns
`default_nettype none
module tpd_stream_src #(
    parameter int COL = 26
) (
    input  wire logic       clk,
    input  wire logic       alarm_mode,
    input  wire logic       tsf_req,
    input  wire logic [7:0] payload,
    output var  logic [7:0] data,
    output var  logic       fs,
    output var  logic       tsf
);
    import tpd_pkg::*;
    // pointer with new data flag so the sink locks on the first valid frame
    localparam logic [9:0] PTR = 10'h011;
    logic       [5:0] col_r = 6'h00;
    logic       [7:0] tb_r  = 8'h00;
    wire  logic       own   = (col_r == 6'(COL));
    wire  logic [7:0] v1    = alarm_mode ? TPD_ONES : {TPD_NDF_EN, 2'b10, PTR[9:8]};
    wire  logic [7:0] v2    = alarm_mode ? TPD_ONES : PTR[7:0];
    // other columns carry the inverse so a wrong pick shows in the data
    wire  logic [7:0] own_b = (tb_r == 8'h00) ? v1 : (tb_r == 8'h24) ? v2 : payload;
    wire  logic [7:0] b_nxt = own ? own_b : ~payload;
    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk) begin
        col_r <= (col_r == 6'h3b) ? 6'h00 : col_r + 6'h01;
        if (col_r == 6'h3b) begin
            tb_r <= (tb_r == 8'h8f) ? 8'h00 : tb_r + 8'h01;
        end
        data <= b_nxt;
        fs   <= (col_r == 6'h00) && (tb_r == 8'h00);
        tsf  <= tsf_req;
    end
endmodule : tpd_stream_src
`default_nettype wire

// File: sim/tpd_sink_bench.sv
/*
 * Self-checking bench for the pointer demap sink, VC-12 at group 7 member 2.
 * Assumes the stream source model upstream and a scoreboard queue of notes.
 */
`timescale 1ns/1ns
`default_nettype none
module tpd_sink_bench;
    import tpd_pkg::*;
    localparam int MF = 13824; // sys cycles per multiframe
    logic        sys_clk = 1'b0, lclk = 1'b0, rst_b = 1'b0;
    logic        act = 1'b0, opt = 1'b0, ordy = 1'b0, tsf_req = 1'b0, alarm = 1'b0;
    logic  [7:0] pay = 8'h01, gdata, od, od11;
    logic        gfs, gtsf, grdy, ov, ofs, ossf, oac, olc, ossf11;
    logic [11:0] q[$];
    logic [11:0] n;
    int          err_total = 0, checks = 0, fs_cnt = 0, seed = 32'hb73fb150;

    initial forever #10 sys_clk = ~sys_clk;
    initial begin
        #7;
        forever #16 lclk = ~lclk;
    end
    ////////////////////////////////////////////////////////////////////////
    tpd_stream_src #(.COL(26)) SRC (.clk(lclk), .alarm_mode(alarm), .tsf_req(tsf_req), .payload(pay),
        .data(gdata), .fs(gfs), .tsf(gtsf));
    tpd_sink #(.VARIANT(TPD_VC12), .GRP_IDX(7), .MEM_IDX(2), .RESP_CYC(16)) DUT (
        .sys_clk(sys_clk), .rst_b(rst_b), .group_input_clock(lclk), .group_input_data(gdata),
        .group_input_frame_start(gfs), .input_trail_fail(gtsf), .group_input_ready(grdy),
        .mgmt_activate(act), .alarm_report_option(opt), .output_ready(ordy), .output_valid(ov),
        .output_data(od), .output_frame_start(ofs), .output_server_fail(ossf),
        .alarm_fault_cause(oac), .pointer_loss_fault_cause(olc));
    // same tributary through the VC-11 variant, which shares the TU-12 pointer
    tpd_sink #(.VARIANT(TPD_VC11), .GRP_IDX(7), .MEM_IDX(2), .RESP_CYC(16)) DUT_VC11 (
        .sys_clk(sys_clk), .rst_b(rst_b), .group_input_clock(lclk), .group_input_data(gdata),
        .group_input_frame_start(gfs), .input_trail_fail(gtsf), .group_input_ready(),
        .mgmt_activate(act), .alarm_report_option(opt), .output_ready(ordy), .output_valid(),
        .output_data(od11), .output_frame_start(), .output_server_fail(ossf11),
        .alarm_fault_cause(), .pointer_loss_fault_cause());
    ////////////////////////////////////////////////////////////////////////
    task automatic cmp(input logic [10:0] got, input logic [10:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp

    task automatic cyc(input int k);
        repeat (k) @(posedge sys_clk);
    endtask : cyc

    // care: compare server fail too; the note waits for the next output byte
    task automatic note(input logic care, input logic [7:0] d, input logic s, input logic a,
                        input logic l);
        int k;
        q.push_back({care, d, s, a, l});
        for (k = 0; k < 400 && q.size() > 0; k++) @(posedge sys_clk);
        if (q.size() > 0) begin
            q.delete();
            cmp(11'h000, 11'h7ff);
        end
    endtask : note

    task automatic tally_and_finish();
        $display("errors=%0d checks=%0d", err_total, checks);
        if (err_total == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : tally_and_finish
    ////////////////////////////////////////////////////////////////////////
    always @(posedge sys_clk) begin
        if (ofs === 1'b1) fs_cnt++;
        if (ov === 1'b1 && q.size() > 0) begin
            n = q.pop_front();
            cmp({od, n[11] ? ossf : n[2], oac, olc}, n[10:0]);
        end
    end

    initial begin
        #1800000;
        err_total++;
        tally_and_finish();
    end

    initial begin
        cyc(5);
        rst_b <= 1'b1;
        act   <= 1'b1;
        ordy  <= 1'b1;
        pay   <= {1'b0, 6'($random(seed)), 1'b1};
        cyc(30);
        note(1'b1, 8'hff, 1'b1, 1'b0, 1'b1);
        tsf_req <= 1'b1;
        cyc(20);
        note(1'b1, 8'hff, 1'b1, 1'b0, 1'b0);
        tsf_req <= 1'b0;
        cyc(2 * MF);
        note(1'b1, pay, 1'b0, 1'b0, 1'b0);
        cmp({10'h000, fs_cnt > 0}, 11'h001);
        cmp({od11, ossf11, 2'b00}, {pay, 1'b0, 2'b00});
        // stall the client long enough to fill the buffer, then drain
        ordy <= 1'b0;
        cyc(2000);
        cmp({10'h000, grdy}, 11'h000);
        ordy <= 1'b1;
        cyc(200);
        note(1'b1, pay, 1'b0, 1'b0, 1'b0);
        tsf_req <= 1'b1;
        cyc(20);
        note(1'b1, 8'hff, 1'b1, 1'b0, 1'b0);
        tsf_req <= 1'b0;
        cyc(20);
        note(1'b1, pay, 1'b0, 1'b0, 1'b0);
        act <= 1'b0;
        cyc(20);
        note(1'b0, 8'hff, 1'b0, 1'b0, 1'b0);
        act <= 1'b1;
        @(posedge gfs);
        @(posedge sys_clk);
        alarm <= 1'b1;
        cyc(31400);
        note(1'b1, 8'hff, 1'b1, 1'b0, 1'b0);
        opt <= 1'b1;
        cyc(20);
        note(1'b1, 8'hff, 1'b1, 1'b1, 1'b0);
        tsf_req <= 1'b1;
        cyc(20);
        note(1'b1, 8'hff, 1'b1, 1'b0, 1'b0);
        act     <= 1'b0;
        tsf_req <= 1'b0;
        cyc(20);
        note(1'b0, 8'hff, 1'b0, 1'b0, 1'b0);
        tally_and_finish();
    end
endmodule : tpd_sink_bench
`default_nettype wire
